// ===== hw/timer_capture_compare.sv
// Purpose: two input-capture and two output-compare channels on a 16-bit counter
// Assumes: APB slave, one clock, synchronous active-high reset
// Notes: pulse generation of single-pulse and PWM modes lives elsewhere
`timescale 1ns/1ps
`include "timer_cc_defines.svh"

module timer_capture_compare (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capturePinOne,
  input wire logic capturePinTwo,
  input wire logic extClockPin,
  input wire logic cpuIntMask,
  output logic comparePinOne,
  output logic comparePinTwo,
  output logic comparePinOneOe,
  output logic comparePinTwoOe,
  output logic timerIrq
);

  timer_cc_pkg::state_s s_q;
  timer_cc_pkg::state_s s_d;
  logic acc;
  logic wr;
  logic rd;
  logic modeActive;
  logic [1:0] capEv;
  logic [1:0] cmpEv;
  logic [1:0] edgeSel;
  logic tick;

  // Offset of a per-channel register
  function automatic logic [11:0] chanOff(input logic [11:0] base, input int idx);
    chanOff = (idx == 0) ? base : 12'(base + `OFF_CHAN_STEP);
  endfunction

  // Active edge from the second and third synchroniser stages
  function automatic logic edgeHit(input logic [2:0] syn, input logic rising);
    edgeHit = rising ? (syn[1] & ~syn[2]) : (~syn[1] & syn[2]);
  endfunction

  // Match point depends on the timer clock
  function automatic logic [15:0] matchAt(input logic [15:0] val, input logic [1:0] sel);
    matchAt = (sel == `CLK_DIV2) ? val : 16'(val + 16'h0001);
  endfunction

  // Prescaler terminal count per clock select
  function automatic logic tickSel(input logic [2:0] pre, input logic [1:0] sel,
                                   input logic [2:0] ext);
    case (sel)
      `CLK_DIV2: tickSel = pre[0];
      `CLK_DIV4: tickSel = &pre[1:0];
      `CLK_DIV8: tickSel = &pre;
      default: tickSel = ext[1] & ~ext[2];
    endcase
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `OFF_ALT_LO);
  endfunction

  // Read mux; reading has no side effect here, effects come at completion
  function automatic logic [7:0] rdByte(input logic [11:0] a, input timer_cc_pkg::state_s s);
    rdByte = 8'h00;
    case (a)
      `OFF_CTRL_A: rdByte = s.ctrlA;
      `OFF_CTRL_B: rdByte = s.ctrlB;
      `OFF_STATUS: rdByte = {s.capFlag[0], s.cmpFlag[0], s.capFlag[1], s.cmpFlag[1], 4'h0};
      `OFF_CNT_HI, `OFF_ALT_HI: rdByte = s.count[15:8];
      `OFF_CNT_LO, `OFF_ALT_LO: rdByte = s.count[7:0];
      default:
      begin
        for (int i = 0; i < 2; i++)
        begin
          if (a == chanOff(`OFF_CAP_ONE_HI, i)) rdByte = s.cap[i][15:8];
          if (a == chanOff(`OFF_CAP_ONE_LO, i)) rdByte = s.cap[i][7:0];
          if (a == chanOff(`OFF_CMP_ONE_HI, i)) rdByte = s.cmp[i][15:8];
          if (a == chanOff(`OFF_CMP_ONE_LO, i)) rdByte = s.cmp[i][7:0];
        end
      end
    endcase
  endfunction

  // Bus completion strobes: one wait state, so every answer comes from a flip-flop
  assign acc = psel & penable & s_q.ready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign modeActive = s_q.ctrlB[`B_PWM] | s_q.ctrlB[`B_SPM];
  assign edgeSel[0] = s_q.ctrlA[`A_EDGE_ONE];
  assign edgeSel[1] = s_q.ctrlB[`B_EDGE_TWO];
  assign tick = tickSel(s_q.pre, s_q.ctrlB[`B_CLK_HI:`B_CLK_LO], s_q.ext);

  // Capture events; channel one is lent to the pulse modes
  assign capEv[0] = edgeHit(s_q.syn[0], edgeSel[0]) & ~s_q.capBlk[0] & ~modeActive;
  assign capEv[1] = edgeHit(s_q.syn[1], edgeSel[1]) & ~s_q.capBlk[1];

  // Compare events, checked once per new count value
  assign cmpEv[0] = s_q.newCount & ~s_q.cmpHold[0] & ~modeActive
    & (s_q.count == matchAt(s_q.cmp[0], s_q.ctrlB[`B_CLK_HI:`B_CLK_LO]));
  assign cmpEv[1] = s_q.newCount & ~s_q.cmpHold[1] & ~s_q.ctrlB[`B_PWM]
    & (s_q.count == matchAt(s_q.cmp[1], s_q.ctrlB[`B_CLK_HI:`B_CLK_LO]));

  // Next-state logic for the whole block
  always_comb
  begin
    s_d = s_q;
    // Bus phase: answer one cycle into the access phase
    s_d.ready = psel & penable & ~s_q.ready;
    if (psel & penable & ~s_q.ready)
    begin
      s_d.rdata = rdByte(paddr, s_q);
      s_d.slvErr = ~mapped(paddr);
    end
    // Prescaler free-runs; external clock enters through a synchroniser
    s_d.pre = 3'(s_q.pre + 3'h1);
    s_d.ext = {s_q.ext[1:0], extClockPin};
    s_d.newCount = tick;
    if (tick)
      s_d.count = 16'(s_q.count + 16'h0001);
    if (wr && (paddr == `OFF_CNT_LO || paddr == `OFF_ALT_LO))
      s_d.count = `CNT_RESET;
    // Control writes; force bits act once and are not stored
    if (wr && paddr == `OFF_CTRL_A)
      s_d.ctrlA = pwdata[7:0] & `A_STORE_MASK;
    if (wr && paddr == `OFF_CTRL_B)
      s_d.ctrlB = pwdata[7:0];
    // Status read arms the clear of the flags set at its completion, one cycle after its byte is latched
    if (rd && paddr == `OFF_STATUS)
    begin
      s_d.capArm = s_q.capFlag;
      s_d.cmpArm = s_q.cmpFlag;
    end
    s_d.syn[0] = {s_q.syn[0][1:0], capturePinOne};
    s_d.syn[1] = {s_q.syn[1][1:0], capturePinTwo};
    // Channels run side by side with no shared lock
    for (int i = 0; i < 2; i++)
    begin
      // Capture high-byte read locks the channel until its low byte is read
      if (rd && paddr == chanOff(`OFF_CAP_ONE_HI, i))
        s_d.capBlk[i] = 1'b1;
      if (acc && paddr == chanOff(`OFF_CAP_ONE_LO, i))
      begin
        if (!pwrite)
          s_d.capBlk[i] = 1'b0;
        if (s_q.capArm[i])
          s_d.capFlag[i] = 1'b0;
        s_d.capArm[i] = 1'b0;
      end
      // Writes to capture registers leave their value alone; a low-byte write still clears an armed flag
      if (capEv[i])
      begin
        s_d.cap[i] = s_q.count;
        s_d.capFlag[i] = 1'b1;
      end
      // Compare high-byte write holds off matching until the low byte lands
      if (wr && paddr == chanOff(`OFF_CMP_ONE_HI, i))
      begin
        s_d.cmp[i][15:8] = pwdata[7:0];
        s_d.cmpHold[i] = 1'b1;
      end
      if (acc && paddr == chanOff(`OFF_CMP_ONE_LO, i))
      begin
        if (pwrite)
        begin
          s_d.cmp[i][7:0] = pwdata[7:0];
          s_d.cmpHold[i] = 1'b0;
        end
        if (s_q.cmpArm[i])
          s_d.cmpFlag[i] = 1'b0;
        s_d.cmpArm[i] = 1'b0;
      end
      // A match in the same cycle as a clear wins
      if (cmpEv[i])
      begin
        s_d.cmpFlag[i] = 1'b1;
        if (s_q.ctrlB[`B_OUTEN_ONE - i])
          s_d.pin[i] = s_q.ctrlA[`A_LEVEL_ONE + i];
      end
      // Forced output: no flag, no request, ignored in the pulse modes
      if (wr && paddr == `OFF_CTRL_A && pwdata[`A_FORCE_ONE + i] && !modeActive
          && s_q.ctrlB[`B_OUTEN_ONE - i])
        s_d.pin[i] = pwdata[`A_LEVEL_ONE + i];
    end
    // Request stays pending behind the CPU mask, re-asserts when it clears
    s_d.irq = ~cpuIntMask
      & ((s_q.ctrlA[`A_CAP_IE] & |s_q.capFlag)
       | (s_q.ctrlA[`A_CMP_IE] & |s_q.cmpFlag));
  end

  // State register; compare pins are held low in reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.cmp <= {`CMP_RESET, `CMP_RESET};
      s_q.count <= `CNT_RESET;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from state flip-flops
  assign prdata = {24'h000000, s_q.rdata};
  assign pready = s_q.ready;
  assign pslverr = s_q.slvErr;
  assign comparePinOne = s_q.pin[0];
  assign comparePinTwo = s_q.pin[1];
  assign comparePinOneOe = s_q.ctrlB[`B_OUTEN_ONE];
  assign comparePinTwoOe = s_q.ctrlB[`B_OUTEN_ONE - 1];
  assign timerIrq = s_q.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Steps of the two-step flag clear
  sequence statusRead;
    rd && paddr == `OFF_STATUS;
  endsequence

  sequence capLowAccess;
    acc && paddr == `OFF_CAP_ONE_LO;
  endsequence

  sequence cmpLowAccess;
    acc && paddr == `OFF_CMP_ONE_LO;
  endsequence

  // First step of each 16-bit access pair
  sequence capHighRead;
    rd && paddr == `OFF_CAP_ONE_HI;
  endsequence

  sequence cmpHighWrite;
    wr && paddr == `OFF_CMP_ONE_HI;
  endsequence

  capture_load_a: assert property (capEv[0] |=> s_q.cap[0] == $past(s_q.count))
    else $error("capture one did not latch the counter");

  capture_ro_a: assert property (wr && !capEv[0]
    && (paddr == `OFF_CAP_ONE_HI || paddr == `OFF_CAP_ONE_LO) |=> $stable(s_q.cap[0]))
    else $error("capture register changed on a write");

  capture_block_a: assert property (s_q.capBlk[1] |=> $stable(s_q.cap[1]))
    else $error("capture two loaded while blocked");

  mode_capture_a: assert property (modeActive |=> $stable(s_q.cap[0]))
    else $error("capture one active in pulse mode");

  status_arm_a: assert property (statusRead |=> s_q.capArm == $past(s_q.capFlag))
    else $error("status read did not arm capture clear");

  capture_clear_a: assert property (capLowAccess and s_q.capArm[0] && !capEv[0]
    |=> !s_q.capFlag[0])
    else $error("capture flag not cleared by low access");

  capture_keep_a: assert property (capLowAccess and !s_q.capArm[0] && s_q.capFlag[0]
    |=> s_q.capFlag[0])
    else $error("capture flag cleared without status read");

  compare_clear_a: assert property (cmpLowAccess and s_q.cmpArm[0] && !cmpEv[0]
    |=> !s_q.cmpFlag[0])
    else $error("compare flag not cleared by low access");

  compare_hold_a: assert property (s_q.cmpHold[0] |-> !cmpEv[0])
    else $error("compare matched while held");

  irq_mask_a: assert property (cpuIntMask |=> !timerIrq)
    else $error("interrupt raised under CPU mask");

  irq_pending_a: assert property (s_q.ctrlA[`A_CAP_IE] && s_q.capFlag[0]
    && !cpuIntMask ##1 s_q.capFlag[0] |-> timerIrq)
    else $error("pending capture interrupt not raised");

  out_disabled_a: assert property (!s_q.ctrlB[`B_OUTEN_ONE] |=> $stable(s_q.pin[0]))
    else $error("disabled compare pin changed");

  match_pin_a: assert property (cmpEv[0] && s_q.ctrlB[`B_OUTEN_ONE]
    && !(wr && paddr == `OFF_CTRL_A)
    |=> comparePinOne == $past(s_q.ctrlA[`A_LEVEL_ONE]) && s_q.cmpFlag[0])
    else $error("match did not set flag and pin");

  reload_a: assert property (wr && paddr == `OFF_ALT_LO |=> s_q.count == `CNT_RESET)
    else $error("counter not reloaded");

  reload_main_a: assert property (wr && paddr == `OFF_CNT_LO |=> s_q.count == `CNT_RESET)
    else $error("counter not reloaded by main low byte");

  // Capture side, both channels
  capture_block_one_a: assert property (s_q.capBlk[0] |=> $stable(s_q.cap[0]))
    else $error("capture one loaded while blocked");

  capture_load_two_a: assert property (capEv[1] |=> s_q.cap[1] == $past(s_q.count))
    else $error("capture two did not latch the counter");

  capture_flag_a: assert property (capEv[0] |=> s_q.capFlag[0])
    else $error("capture one did not set its flag");

  capture_flag_two_a: assert property (capEv[1] |=> s_q.capFlag[1])
    else $error("capture two did not set its flag");

  high_read_block_a: assert property (capHighRead |=> s_q.capBlk[0])
    else $error("high byte read did not block capture one");

  low_read_unblock_a: assert property (rd && paddr == `OFF_CAP_ONE_LO |=> !s_q.capBlk[0])
    else $error("low byte read did not release capture one");

  capture_ro_two_a: assert property (wr && !capEv[1]
    && (paddr == `OFF_CAP_ONE_HI + `OFF_CHAN_STEP || paddr == `OFF_CAP_ONE_LO + `OFF_CHAN_STEP)
    |=> $stable(s_q.cap[1]))
    else $error("capture two changed on a write");

  // Compare side: value, hold and match point
  compare_sw_a: assert property (!(wr && (paddr == `OFF_CMP_ONE_HI
    || paddr == `OFF_CMP_ONE_LO)) |=> $stable(s_q.cmp[0]))
    else $error("compare one changed without a write");

  hold_set_a: assert property (cmpHighWrite |=> s_q.cmpHold[0])
    else $error("high byte write did not hold compare one");

  compare_hold_two_a: assert property (s_q.cmpHold[1] |-> !cmpEv[1])
    else $error("compare two matched while held");

  compare_flag_two_a: assert property (cmpEv[1] |=> s_q.cmpFlag[1])
    else $error("compare two did not set its flag");

  match_div2_a: assert property (cmpEv[0]
    && s_q.ctrlB[`B_CLK_HI:`B_CLK_LO] == `CLK_DIV2 |-> s_q.count == s_q.cmp[0])
    else $error("compare one matched off its value");

  match_slow_a: assert property (cmpEv[0]
    && s_q.ctrlB[`B_CLK_HI:`B_CLK_LO] != `CLK_DIV2 |-> s_q.count == 16'(s_q.cmp[0] + 16'h0001))
    else $error("compare one matched off its value plus one");

  status_cmp_a: assert property (statusRead |=> s_q.cmpArm == $past(s_q.cmpFlag))
    else $error("status read did not arm compare clear");

  compare_keep_a: assert property (cmpLowAccess and !s_q.cmpArm[0] && s_q.cmpFlag[0]
    |=> s_q.cmpFlag[0])
    else $error("compare flag cleared without status read");

  pin_two_a: assert property (cmpEv[1] && s_q.ctrlB[`B_OUTEN_ONE - 1]
    && !(wr && paddr == `OFF_CTRL_A) |=> comparePinTwo == $past(s_q.ctrlA[`A_LEVEL_ONE + 1]))
    else $error("match did not drive compare pin two");

  out_disabled_two_a: assert property (!s_q.ctrlB[`B_OUTEN_ONE - 1] |=> $stable(s_q.pin[1]))
    else $error("disabled compare pin two changed");

  // Forced output: pin only, never flag or request
  force_pin_a: assert property (wr && paddr == `OFF_CTRL_A && pwdata[`A_FORCE_ONE]
    && !modeActive && s_q.ctrlB[`B_OUTEN_ONE] |=> comparePinOne == $past(pwdata[`A_LEVEL_ONE]))
    else $error("force did not copy level to pin one");

  force_flag_a: assert property (wr && paddr == `OFF_CTRL_A && pwdata[`A_FORCE_ONE]
    && !cmpEv[0] && !s_q.cmpFlag[0] |=> !s_q.cmpFlag[0])
    else $error("force set the compare flag");

  force_mode_a: assert property (modeActive |=> $stable(s_q.pin[0]))
    else $error("compare pin one moved in pulse mode");

  // Request level and bus answer
  irq_compare_a: assert property (s_q.ctrlA[`A_CMP_IE] && s_q.cmpFlag[0]
    && !cpuIntMask |=> timerIrq)
    else $error("compare interrupt not raised");

  irq_idle_a: assert property (s_q.capFlag == 2'h0
    && s_q.cmpFlag == 2'h0 |=> !timerIrq)
    else $error("interrupt raised with no flag set");

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held for two cycles");

endmodule

// ===== include/timer_cc_defines.svh
// Purpose: register map, field positions and reset values of the capture/compare timer
// Assumes: APB byte addresses, one register per aligned word, data in bits 7:0
// Notes: definitions only
`ifndef TIMER_CC_DEFINES_SVH
`define TIMER_CC_DEFINES_SVH

`define OFF_CTRL_A 12'h000
`define OFF_CTRL_B 12'h004
`define OFF_STATUS 12'h008
`define OFF_CAP_ONE_HI 12'h00C
`define OFF_CAP_ONE_LO 12'h010
`define OFF_CMP_ONE_HI 12'h01C
`define OFF_CMP_ONE_LO 12'h020
`define OFF_CHAN_STEP 12'h008
`define OFF_CNT_HI 12'h02C
`define OFF_CNT_LO 12'h030
`define OFF_ALT_HI 12'h034
`define OFF_ALT_LO 12'h038

// Control A fields
`define A_CAP_IE 7
`define A_CMP_IE 6
`define A_FORCE_ONE 4
`define A_EDGE_ONE 2
`define A_LEVEL_ONE 0
`define A_STORE_MASK 8'hC7
// Control B fields
`define B_OUTEN_ONE 7
`define B_PWM 5
`define B_SPM 4
`define B_CLK_HI 3
`define B_CLK_LO 2
`define B_EDGE_TWO 1
// Status fields: channel one at 7/6, channel two at 5/4
`define S_CAP_ONE 7
`define S_CMP_ONE 6

`define CLK_DIV2 2'h0
`define CLK_DIV4 2'h1
`define CLK_DIV8 2'h2
`define CLK_EXT 2'h3

`define CMP_RESET 16'h8000
`define CNT_RESET 16'hFFFC

`endif

// ===== include/timer_cc_pkg.sv
// Purpose: state record of the capture/compare timer
// Assumes: one struct holds every flip-flop of the block
// Notes: index 0 is channel one, index 1 channel two
package timer_cc_pkg;

  typedef struct packed {
    logic ready;
    logic slvErr;
    logic [7:0] rdata;
    logic [7:0] ctrlA;
    logic [7:0] ctrlB;
    logic [1:0][15:0] cap;
    logic [1:0][15:0] cmp;
    logic [1:0] capFlag;
    logic [1:0] cmpFlag;
    logic [1:0] capArm;
    logic [1:0] cmpArm;
    logic [1:0] capBlk;
    logic [1:0] cmpHold;
    logic [1:0][2:0] syn;
    logic [2:0] ext;
    logic [2:0] pre;
    logic [15:0] count;
    logic newCount;
    logic [1:0] pin;
    logic irq;
  } state_s;

endpackage

// ===== tb/pin_partner.sv
// Purpose: far side of the timer pins, capture sources and compare loads
// Assumes: compare pads carry a pull-down when not driven
// Notes: bench sets the wanted capture levels
`timescale 1ns/1ps

module pin_partner (
  input wire logic wantOne,
  input wire logic wantTwo,
  input wire logic comparePinOne,
  input wire logic comparePinOneOe,
  input wire logic comparePinTwo,
  input wire logic comparePinTwoOe,
  output logic capturePinOne,
  output logic capturePinTwo,
  output logic padOne,
  output logic padTwo
);
  // Capture pins always follow the source, any edge reaches the timer
  assign capturePinOne = wantOne;
  assign capturePinTwo = wantTwo;
  // Undriven pad falls to the pull-down, never the stale level
  assign padOne = comparePinOneOe ? comparePinOne : 1'b0;
  assign padTwo = comparePinTwoOe ? comparePinTwo : 1'b0;
endmodule

// ===== tb/timer_capture_compare_tb.sv
// Purpose: self-checking bench of the capture/compare timer
// Assumes: one wait state per APB access, byte data in bits 7:0
// Notes: capture values checked within one tick, phase of prescaler unknown
`timescale 1ns/1ps

module timer_capture_compare_tb;
  typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e; logic r;} row_s;
  logic clk, sysRst, psel, penable, pwrite, wantOne, wantTwo, mask, extClk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, cOne, cTwo, pOne, pTwo, oeOne, oeTwo, irq, padOne, padTwo;
  logic [7:0] rd;
  logic er;
  int n_mismatch = 0;
  int n_tests = 0;
  row_s rows [6] = '{'{0, 12'h01C, 8'h00, 8'h80, 0}, '{0, 12'h024, 8'h00, 8'h80, 0},
    '{1, 12'h028, 8'h34, 8'h00, 0}, '{0, 12'h028, 8'h00, 8'h34, 0},
    '{0, 12'h03C, 8'h00, 8'h00, 1}, '{1, 12'h03C, 8'h77, 8'h00, 1}};

  timer_capture_compare dut_u (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capturePinOne(cOne), .capturePinTwo(cTwo), .extClockPin(extClk),
    .cpuIntMask(mask), .comparePinOne(pOne), .comparePinTwo(pTwo),
    .comparePinOneOe(oeOne), .comparePinTwoOe(oeTwo), .timerIrq(irq));
  pin_partner far_u (.wantOne(wantOne), .wantTwo(wantTwo), .comparePinOne(pOne),
    .comparePinOneOe(oeOne), .comparePinTwo(pTwo), .comparePinTwoOe(oeTwo),
    .capturePinOne(cOne), .capturePinTwo(cTwo), .padOne(padOne), .padTwo(padTwo));

  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; answer taken at the rising edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 20)
    begin
      chk("pready", 8'h01, 8'h00);
      stop_test();
    end
    rd = prdata[7:0];
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic pins(input logic one, input logic two);
    @(posedge clk);
    wantOne <= one;
    wantTwo <= two;
    repeat (8) @(posedge clk);
  endtask

  task automatic stop_test;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    #300000;
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    sysRst = 1;
    {psel, penable, pwrite, wantOne, wantTwo, extClk} = '0;
    mask = 1;
    paddr = '0;
    pwdata = '0;
    repeat (6) @(posedge clk);
    sysRst <= 0;
    chk("pin one", 8'h00, {7'h00, pOne});
    // Table of plain accesses
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk("read", rows[i].e, rd);
      chk("slverr", {7'h00, rows[i].r}, {7'h00, er});
    end
    $display("test table done");
    // Capture one, div8, reload counter just before the edge
    apb(1, 12'h004, 8'h08);
    apb(1, 12'h000, 8'h84);
    apb(1, 12'h030, 8'h00);
    pins(1, 0);
    apb(0, 12'h008, 8'h00);
    chk("cap flag", 8'h80, rd & 8'h80);
    chk("irq masked", 8'h00, {7'h00, irq});
    mask <= 0;
    repeat (3) @(posedge clk);
    chk("irq", 8'h01, {7'h00, irq});
    apb(0, 12'h00C, 8'h00);
    chk("cap hi", 8'hFF, rd);
    apb(1, 12'h00C, 8'h55);
    apb(0, 12'h00C, 8'h00);
    chk("cap hi kept", 8'hFF, rd);
    pins(0, 0);
    pins(1, 0);
    apb(0, 12'h010, 8'h00);
    chk("cap lo", 8'hFC, rd & 8'hFE);
    apb(0, 12'h008, 8'h00);
    chk("flag cleared", 8'h00, rd & 8'h80);
    chk("irq low", 8'h00, {7'h00, irq});
    apb(1, 12'h000, 8'h80);
    pins(0, 0);
    apb(0, 12'h008, 8'h00);
    chk("falling edge", 8'h80, rd & 8'h80);
    apb(0, 12'h010, 8'h00);
    // Single-pulse mode leaves only channel two capturing
    apb(1, 12'h004, 8'h18);
    pins(1, 1);
    pins(0, 0);
    apb(0, 12'h008, 8'h00);
    chk("mode flags", 8'h20, rd & 8'hA0);
    $display("test capture done");
    // Compare one at 0010h, div2, pin enabled
    apb(1, 12'h004, 8'h80);
    apb(1, 12'h000, 8'h41);
    apb(1, 12'h01C, 8'h00);
    apb(0, 12'h008, 8'h00);
    apb(1, 12'h030, 8'h00);
    apb(1, 12'h020, 8'h10);
    for (int k = 0; k < 200 && pOne !== 1'b1; k++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    chk("pad one", 8'h01, {7'h00, padOne});
    chk("irq cmp", 8'h01, {7'h00, irq});
    apb(0, 12'h008, 8'h00);
    chk("cmp flag", 8'h40, rd & 8'h40);
    apb(1, 12'h020, 8'h10);
    apb(0, 12'h008, 8'h00);
    chk("cmp cleared", 8'h00, rd & 8'h40);
    apb(1, 12'h000, 8'h50);
    repeat (3) @(posedge clk);
    chk("forced pad", 8'h00, {7'h00, padOne});
    chk("force irq", 8'h00, {7'h00, irq});
    apb(0, 12'h008, 8'h00);
    chk("force flag", 8'h00, rd & 8'h40);
    apb(1, 12'h004, 8'h90);
    apb(1, 12'h000, 8'h11);
    repeat (3) @(posedge clk);
    chk("pulse mode force", 8'h00, {7'h00, padOne});
    apb(1, 12'h004, 8'h00);
    repeat (2) @(posedge clk);
    chk("oe off", 8'h00, {7'h00, oeOne});
    // High byte alone keeps matching suspended; alternate low byte reloads
    apb(1, 12'h01C, 8'h00);
    apb(1, 12'h038, 8'h00);
    repeat (80) @(posedge clk);
    apb(0, 12'h008, 8'h00);
    chk("suspended", 8'h00, rd & 8'h40);
    // Pin forced high so the reset has something to pull low
    apb(1, 12'h004, 8'h80);
    apb(1, 12'h000, 8'h11);
    repeat (2) @(posedge clk);
    chk("forced high", 8'h01, {7'h00, padOne});
    $display("test compare done");
    // Second reset in mid-run
    sysRst <= 1;
    repeat (2) @(posedge clk);
    sysRst <= 0;
    apb(0, 12'h01C, 8'h00);
    chk("cmp hi reset", 8'h80, rd);
    chk("pin reset", 8'h00, {7'h00, pOne});
    $display("test reset done");
    // External clock: three slow pulses step the counter three times
    apb(1, 12'h004, 8'h0C);
    apb(1, 12'h030, 8'h00);
    repeat (3)
    begin
      @(posedge clk);
      extClk <= 1'b1;
      repeat (4) @(posedge clk);
      extClk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    apb(0, 12'h030, 8'h00);
    chk("ext count", 8'hFF, rd);
    $display("test external clock done");
    stop_test();
  end
endmodule
